// ### hw/atwrs_pkg.sv
// shared constants and types for the two-wire readout sequencer
package atwrs_pkg;

    // clocking
    localparam int CLK_PERIOD_NS  = 50;

    // widths
    localparam int WORD_BITS      = 24;
    localparam int FIFO_DEPTH     = 16;
    localparam int PTR_BITS       = 5;
    localparam int TMR_BITS       = 23;
    localparam int HOLD_BITS      = 12;
    localparam int EXT_BITS       = 7;

    // shift-edge landmarks, counted from data ready
    localparam logic [4:0] LAST_BIT_EDGE = 5'h18;
    localparam logic [4:0] IDLE_HI_EDGE  = 5'h19;
    localparam logic [4:0] CAL_EDGE      = 5'h1A;
    localparam logic [4:0] IDX_IDLE      = 5'h1F;

    // times in ns, as printed
    localparam int UPDATE_FAST_NS   = 155000;
    localparam int UPDATE_SLOW_NS   = 169000;
    localparam int CONV_FAST_NS     = 8600000;
    localparam int CONV_SLOW_NS     = 73000000;
    localparam int CAL_FAST_NS      = 208300000;
    localparam int CAL_SLOW_NS      = 256100000;
    localparam int WAKECAL_FAST_NS  = 208400000;
    localparam int WAKECAL_SLOW_NS  = 256200000;
    localparam int SLEEP_HOLD_NS    = 100000;
    localparam int EXT_TIMEOUT_NS   = 3200;

    // least times round up to whole cycles
    function automatic int ns2cyc(input int ns);
        return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    endfunction

    localparam int UPDATE_FAST_CYC  = ns2cyc(UPDATE_FAST_NS);
    localparam int UPDATE_SLOW_CYC  = ns2cyc(UPDATE_SLOW_NS);
    localparam int CONV_FAST_CYC    = ns2cyc(CONV_FAST_NS);
    localparam int CONV_SLOW_CYC    = ns2cyc(CONV_SLOW_NS);
    localparam int CAL_FAST_CYC     = ns2cyc(CAL_FAST_NS);
    localparam int CAL_SLOW_CYC     = ns2cyc(CAL_SLOW_NS);
    localparam int WAKECAL_FAST_CYC = ns2cyc(WAKECAL_FAST_NS);
    localparam int WAKECAL_SLOW_CYC = ns2cyc(WAKECAL_SLOW_NS);
    localparam logic [HOLD_BITS-1:0] SLEEP_HOLD_CYC = HOLD_BITS'(ns2cyc(SLEEP_HOLD_NS));
    localparam logic [EXT_BITS-1:0]  EXT_TIMEOUT_CYC = EXT_BITS'(ns2cyc(EXT_TIMEOUT_NS));

    // sequencer phases, gray along conversion -> update -> conversion
    typedef enum logic [1:0] {
        PH_CAL    = 2'h0,
        PH_CONV   = 2'h1,
        PH_UPDATE = 2'h3,
        PH_SLEEP  = 2'h2
    } atwrs_phase_type;

    typedef struct packed {
        logic                 valid;
        logic [WORD_BITS-1:0] data;
    } atwrs_result_type;

    typedef struct packed {
        logic calActive;
        logic convActive;
        logic sleepActive;
        logic extClkSel;
        logic oscEnable;
    } atwrs_status_type;

endpackage

// ### hw/atwrs_fifo.sv
// flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module atwrs_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    // fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wrPtr;
        logic [AW:0]                 rdPtr;
    } atwrs_fifo_state_type;

    atwrs_fifo_state_type cur_r;
    atwrs_fifo_state_type cur_nxt;

    logic full;
    logic empty;

    // extra pointer bit tells full from empty
    assign empty    = (cur_r.wrPtr == cur_r.rdPtr);
    assign full     = (cur_r.wrPtr[AW-1:0] == cur_r.rdPtr[AW-1:0]) &&
                      (cur_r.wrPtr[AW] != cur_r.rdPtr[AW]);
    assign inReady  = !full;
    assign outValid = !empty;
    assign outData  = cur_r.mem[cur_r.rdPtr[AW-1:0]];

    always_comb begin
        cur_nxt = cur_r;
        if (inValid && !full) begin
            cur_nxt.mem[cur_r.wrPtr[AW-1:0]] = inData;
            cur_nxt.wrPtr = cur_r.wrPtr + 1'b1;
        end
        if (outReady && !empty) begin
            cur_nxt.rdPtr = cur_r.rdPtr + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cur_r <= '0;
        end else begin
            cur_r <= cur_nxt;
        end
    end

endmodule // atwrs_fifo

// ### hw/atwrs_link.sv
// shift-clock domain: gray-coded count of rising shift-clock edges
`timescale 1ns/1ps
module atwrs_link (
    // link clock and reset from the system domain
    input  wire logic                          sclk,
    input  wire logic                          sys_rst,
    // edge count, gray coded, for the system domain
    output logic [atwrs_pkg::PTR_BITS-1:0]     edgeGray
);
    typedef struct packed {
        logic [1:0]                      rstSync;
        logic [atwrs_pkg::PTR_BITS-1:0]  count;
        logic [atwrs_pkg::PTR_BITS-1:0]  gray;
    } atwrs_link_state_type;

    atwrs_link_state_type cur_r;
    atwrs_link_state_type cur_nxt;

    logic [atwrs_pkg::PTR_BITS-1:0] countInc;

    assign countInc = cur_r.count + 1'b1;
    assign edgeGray = cur_r.gray;

    // only one bit of the gray word moves per edge, so the far side never sees a torn count
    always_comb begin
        cur_nxt         = cur_r;
        cur_nxt.rstSync = {cur_r.rstSync[0], sys_rst};
        if (cur_r.rstSync[1]) begin
            cur_nxt.count = '0;
            cur_nxt.gray  = '0;
        end else begin
            cur_nxt.count = countInc;
            cur_nxt.gray  = countInc ^ (countInc >> 1);
        end
    end

    // the reset itself crosses in through rstSync, so it is kept off this process
    always_ff @(posedge sclk) begin
        cur_r <= cur_nxt;
    end

endmodule // atwrs_link

// ### hw/atwrs_sequencer.sv
// conversion sequencing and two-wire readout of the converter
`timescale 1ns/1ps
module atwrs_sequencer #(
    parameter bit FAST_VARIANT    = 1'b1,
    parameter int UPDATE_CYCLES   = FAST_VARIANT ? atwrs_pkg::UPDATE_FAST_CYC
                                                 : atwrs_pkg::UPDATE_SLOW_CYC,
    parameter int CONV_CYCLES     = FAST_VARIANT ? atwrs_pkg::CONV_FAST_CYC
                                                 : atwrs_pkg::CONV_SLOW_CYC,
    parameter int CAL_CYCLES      = FAST_VARIANT ? atwrs_pkg::CAL_FAST_CYC
                                                 : atwrs_pkg::CAL_SLOW_CYC,
    parameter int WAKECAL_CYCLES  = FAST_VARIANT ? atwrs_pkg::WAKECAL_FAST_CYC
                                                 : atwrs_pkg::WAKECAL_SLOW_CYC
) (
    // system clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        sys_rst,
    // two-wire link
    input  wire logic                        sclk,
    output logic                             rdyDout,
    // external system clock pin
    input  wire logic                        extClk,
    // results from the digital filter
    input  wire atwrs_pkg::atwrs_result_type resultIn,
    output logic                             resultReady,
    // status toward the analog side
    output atwrs_pkg::atwrs_status_type      status
);
    localparam int TB = atwrs_pkg::TMR_BITS;
    localparam int PB = atwrs_pkg::PTR_BITS;

    localparam logic [TB-1:0] UPDATE_T  = TB'(UPDATE_CYCLES);
    localparam logic [TB-1:0] CONV_T    = TB'(CONV_CYCLES - 1);
    localparam logic [TB-1:0] CAL_T     = TB'(CAL_CYCLES - 1);
    localparam logic [TB-1:0] WAKECAL_T = TB'(WAKECAL_CYCLES - 1);

    typedef struct packed {
        atwrs_pkg::atwrs_phase_type               phase;
        logic [TB-1:0]                            timer;
        logic [atwrs_pkg::WORD_BITS-1:0]          word;
        logic                                     dout;
        logic [4:0]                               edgeIdx;
        logic                                     calPend;
        logic                                     haveRes;
        logic [atwrs_pkg::HOLD_BITS-1:0]          hiCnt;
        logic [1:0]                               sclkSync;
        logic [PB-1:0]                            ptrSync1;
        logic [PB-1:0]                            ptrSync2;
        logic [PB-1:0]                            lastPtr;
        logic [1:0]                               extSync;
        logic                                     extPrev;
        logic [atwrs_pkg::EXT_BITS-1:0]           extIdle;
        logic                                     useExt;
    } atwrs_seq_state_type;

    // power-on starts with the startup self-calibration
    localparam atwrs_seq_state_type RST_STATE = '{
        phase:    atwrs_pkg::PH_CAL,
        timer:    CAL_T,
        word:     '0,
        dout:     1'b1,
        edgeIdx:  atwrs_pkg::IDX_IDLE,
        calPend:  1'b0,
        haveRes:  1'b0,
        hiCnt:    '0,
        sclkSync: '0,
        ptrSync1: '0,
        ptrSync2: '0,
        lastPtr:  '0,
        extSync:  '0,
        extPrev:  1'b0,
        extIdle:  '0,
        useExt:   1'b0
    };

    atwrs_seq_state_type cur_r;
    atwrs_seq_state_type cur_nxt;

    logic [PB-1:0]                   edgeGray;
    logic [PB-1:0]                   ptrBin;
    logic [PB-1:0]                   edgeDelta;
    logic                            sclkHigh;
    logic                            fifoValid;
    logic [atwrs_pkg::WORD_BITS-1:0] fifoData;
    logic                            popResult;

    function automatic logic [PB-1:0] gray2bin(input logic [PB-1:0] g);
        logic [PB-1:0] b;
        b[PB-1] = g[PB-1];
        for (int i = PB - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    atwrs_link u_link (
        .sclk     (sclk),
        .sys_rst  (sys_rst),
        .edgeGray (edgeGray)
    );

    // results wait here until a conversion period or a calibration closes
    atwrs_fifo #(
        .WIDTH (atwrs_pkg::WORD_BITS),
        .DEPTH (atwrs_pkg::FIFO_DEPTH)
    ) u_fifo (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .inValid  (resultIn.valid),
        .inReady  (resultReady),
        .inData   (resultIn.data),
        .outValid (fifoValid),
        .outReady (popResult),
        .outData  (fifoData)
    );

    assign sclkHigh  = cur_r.sclkSync[1];
    assign ptrBin    = gray2bin(cur_r.ptrSync2);
    assign edgeDelta = ptrBin - cur_r.lastPtr;

    always_comb begin
        logic [5:0] n;
        logic [4:0] bitSel;
        logic       doLoad;
        n         = '0;
        bitSel    = '0;
        doLoad    = 1'b0;
        cur_nxt   = cur_r;
        popResult = 1'b0;

        // synchronisers for pin levels and the edge pointer
        cur_nxt.sclkSync = {cur_r.sclkSync[0], sclk};
        cur_nxt.ptrSync1 = edgeGray;
        cur_nxt.ptrSync2 = cur_r.ptrSync1;
        cur_nxt.lastPtr  = ptrBin;
        cur_nxt.extSync  = {cur_r.extSync[0], extClk};
        cur_nxt.extPrev  = cur_r.extSync[1];

        // a rising edge on the clock pin selects it; silence hands back to the oscillator
        if (cur_r.extSync[1] && !cur_r.extPrev) begin
            cur_nxt.extIdle = '0;
            cur_nxt.useExt  = 1'b1;
        end else if (cur_r.extIdle == atwrs_pkg::EXT_TIMEOUT_CYC) begin
            cur_nxt.useExt  = 1'b0;
        end else begin
            cur_nxt.extIdle = cur_r.extIdle + 1'b1;
        end

        // how long the shift clock has sat high
        if (!sclkHigh) begin
            cur_nxt.hiCnt = '0;
        end else if (cur_r.hiCnt != atwrs_pkg::SLEEP_HOLD_CYC) begin
            cur_nxt.hiCnt = cur_r.hiCnt + 1'b1;
        end

        // shift-clock edges move the output only while a read is open
        if (cur_r.edgeIdx != atwrs_pkg::IDX_IDLE && edgeDelta != '0) begin
            n = {1'b0, cur_r.edgeIdx} + {1'b0, edgeDelta};
            if (n > {1'b0, atwrs_pkg::CAL_EDGE}) begin
                n = {1'b0, atwrs_pkg::CAL_EDGE};
            end
            cur_nxt.edgeIdx = n[4:0];
            if (n[4:0] <= atwrs_pkg::LAST_BIT_EDGE) begin
                bitSel       = atwrs_pkg::LAST_BIT_EDGE - n[4:0];
                cur_nxt.dout = cur_r.word[bitSel];
            end else begin
                cur_nxt.dout = 1'b1;
            end
            if (n[4:0] == atwrs_pkg::CAL_EDGE) begin
                cur_nxt.calPend = 1'b1;
            end
        end

        unique case (cur_r.phase)
            atwrs_pkg::PH_CAL: begin
                cur_nxt.timer = cur_r.timer - 1'b1;
                if (cur_r.timer == '0) begin
                    doLoad = 1'b1;
                end
            end
            atwrs_pkg::PH_CONV: begin
                cur_nxt.timer = cur_r.timer - 1'b1;
                if (cur_r.haveRes && cur_r.hiCnt == atwrs_pkg::SLEEP_HOLD_CYC) begin
                    cur_nxt.phase   = atwrs_pkg::PH_SLEEP;
                    cur_nxt.haveRes = 1'b0;
                    cur_nxt.edgeIdx = atwrs_pkg::IDX_IDLE;
                    cur_nxt.dout    = 1'b1;
                end else if (cur_r.edgeIdx == atwrs_pkg::CAL_EDGE && !sclkHigh) begin
                    // falling edge of the extra pulse
                    cur_nxt.phase   = atwrs_pkg::PH_CAL;
                    cur_nxt.timer   = CAL_T;
                    cur_nxt.calPend = 1'b0;
                    cur_nxt.haveRes = 1'b0;
                    cur_nxt.edgeIdx = atwrs_pkg::IDX_IDLE;
                    cur_nxt.dout    = 1'b1;
                end else if (cur_r.timer == UPDATE_T) begin
                    // reads are closed from here until the new word lands
                    cur_nxt.phase   = atwrs_pkg::PH_UPDATE;
                    cur_nxt.edgeIdx = atwrs_pkg::IDX_IDLE;
                    cur_nxt.dout    = 1'b1;
                end
            end
            atwrs_pkg::PH_UPDATE: begin
                cur_nxt.timer = cur_r.timer - 1'b1;
                if (cur_r.haveRes && cur_r.hiCnt == atwrs_pkg::SLEEP_HOLD_CYC) begin
                    cur_nxt.phase   = atwrs_pkg::PH_SLEEP;
                    cur_nxt.haveRes = 1'b0;
                end else if (cur_r.timer == '0) begin
                    doLoad = 1'b1;
                end
            end
            atwrs_pkg::PH_SLEEP: begin
                if (!sclkHigh) begin
                    if (cur_r.calPend) begin
                        cur_nxt.phase   = atwrs_pkg::PH_CAL;
                        cur_nxt.timer   = WAKECAL_T;
                        cur_nxt.calPend = 1'b0;
                    end else begin
                        cur_nxt.phase = atwrs_pkg::PH_CONV;
                        cur_nxt.timer = CONV_T;
                    end
                end
            end
        endcase

        // a fresh result replaces the held one whether or not it was read
        if (doLoad) begin
            popResult       = fifoValid;
            if (fifoValid) begin
                cur_nxt.word = fifoData;
            end
            cur_nxt.phase   = atwrs_pkg::PH_CONV;
            cur_nxt.timer   = CONV_T;
            cur_nxt.dout    = 1'b0;
            cur_nxt.edgeIdx = '0;
            cur_nxt.haveRes = 1'b1;
            cur_nxt.calPend = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cur_r <= RST_STATE;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    assign rdyDout            = cur_r.dout;
    // one driver for the whole packed status word
    assign status = '{
        calActive:   (cur_r.phase == atwrs_pkg::PH_CAL),
        convActive:  (cur_r.phase == atwrs_pkg::PH_CONV) ||
                     (cur_r.phase == atwrs_pkg::PH_UPDATE),
        sleepActive: (cur_r.phase == atwrs_pkg::PH_SLEEP),
        extClkSel:   cur_r.useExt,
        oscEnable:   !cur_r.useExt && (cur_r.phase != atwrs_pkg::PH_SLEEP)
    };

endmodule // atwrs_sequencer

// ### testbench/atwrs_sequencer_props.sv
// concurrent checks on the readout sequencer's ports
`timescale 1ns/1ps
module atwrs_sequencer_props (
    // clock and reset
    input wire logic                        ref_clk,
    input wire logic                        sys_rst,
    // link and clock pins
    input wire logic                        sclk,
    input wire logic                        rdyDout,
    input wire logic                        extClk,
    // filter side and status
    input wire atwrs_pkg::atwrs_result_type resultIn,
    input wire logic                        resultReady,
    input wire atwrs_pkg::atwrs_status_type status
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    rst_state_a: assert property (
        $fell(sys_rst) |-> rdyDout && status.calActive && status.oscEnable
            && !status.convActive && !status.sleepActive)
        else $error("wrong state after reset release");
    cal_quiet_a: assert property (
        status.calActive |-> rdyDout)
        else $error("ready shown during calibration");
    ext_sel_a: assert property (
        $rose(extClk) |-> ##[1:5] status.extClkSel)
        else $error("external clock edge not taken");
    osc_off_a: assert property (
        status.extClkSel |-> !status.oscEnable)
        else $error("oscillator left running on external clock");
    sleep_high_a: assert property (
        status.sleepActive |-> rdyDout)
        else $error("output low in sleep");
    sleep_cause_a: assert property (
        $rose(status.sleepActive) |-> sclk && $past(sclk, 8))
        else $error("sleep without shift clock held high");
    sleep_idle_a: assert property (
        status.sleepActive |-> !status.convActive && !status.calActive)
        else $error("activity while asleep");
    wake_run_a: assert property (
        $fell(status.sleepActive) |-> ##[0:4] (status.convActive || status.calActive))
        else $error("no conversion after wake");
endmodule // atwrs_sequencer_props

// ### testbench/atwrs_host_model.sv
// host model: drives the shift clock and samples ready/data
`timescale 1ns/1ps
module atwrs_host_model (
    // pacing clock
    input wire logic ref_clk,
    // two-wire link
    output logic     sclk,
    input wire logic rdyDout
);
    initial sclk = 1'b0;

    // 3 ns shift pulse, then five system cycles so the bit has crossed over
    task automatic pulse();
        #2 sclk = 1'b1;
        #3 sclk = 1'b0;
        repeat (5) @(negedge ref_clk);
    endtask

    // reads start right after ready, well clear of the update window
    task automatic readBits(input int n, output logic [23:0] w, output logic lastBit);
        w = '0;
        lastBit = 1'b0;
        for (int i = 0; i < n; i++) begin
            pulse();
            lastBit = rdyDout;
            if (i < 24) w = {w[22:0], rdyDout};
        end
    endtask

    // level held high asks for sleep; held as 26th rise it also asks for calibration
    task automatic hold(input logic v);
        #2 sclk = v;
    endtask
endmodule // atwrs_host_model

// ### testbench/test_adc_two_wire_readout_sequencer.sv
// self-checking bench for the readout sequencer
`timescale 1ns/1ps
module test_adc_two_wire_readout_sequencer;
    // conversions outlast the sleep hold, so no load lands in a hold and drops a pending calibration
    localparam int CONV = 2400;
    localparam int CAL  = 400;
    localparam int WCAL = 402;

    logic                        ref_clk;
    logic                        sys_rst;
    logic                        sclk;
    logic                        rdyDout;
    logic                        extClk;
    logic                        resultReady;
    atwrs_pkg::atwrs_result_type resultIn;
    atwrs_pkg::atwrs_status_type status;
    int                          num_errors = 0;
    int                          compares = 0;
    int                          cyc = 0;
    int                          idx = 0;
    int                          t0;
    int                          seed;
    logic [23:0]                 w;
    logic                        lastBit;
    logic [23:0]                 q[$];

    atwrs_sequencer #(.UPDATE_CYCLES(5), .CONV_CYCLES(CONV), .CAL_CYCLES(CAL),
                      .WAKECAL_CYCLES(WCAL)) i_atwrs_sequencer (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .sclk(sclk), .rdyDout(rdyDout),
        .extClk(extClk), .resultIn(resultIn), .resultReady(resultReady), .status(status));

    atwrs_host_model i_atwrs_host_model (.ref_clk(ref_clk), .sclk(sclk), .rdyDout(rdyDout));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            num_errors++;
            results();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic near(input int got, input int exp);
        return got >= exp - 6 && got <= exp + 6;
    endfunction

    // each ready pops one queued word, so the ready count picks the expected word
    task automatic waitReady();
        int k;
        k = 0;
        while (rdyDout !== 1'b1 && k < 3000) begin
            @(negedge ref_clk);
            k++;
        end
        while (rdyDout !== 1'b0 && k < 3000) begin
            @(negedge ref_clk);
            k++;
        end
        if (k >= 3000) num_errors++;
        idx++;
    endtask

    task automatic readWord(input int n);
        i_atwrs_host_model.readBits(n, w, lastBit);
        check(w, q[idx-1]);
    endtask

    task automatic results();
        $display("errors=%0d compares=%0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        seed = 32'h7536F709;
        sys_rst = 1'b1;
        extClk = 1'b0;
        resultIn = '0;
        // the link counter reset only crosses on shift edges
        repeat (4) i_atwrs_host_model.pulse();
        sys_rst = 1'b0;
        t0 = cyc;
        // the link sees the release two shift edges late; spend them while the device calibrates
        repeat (2) i_atwrs_host_model.pulse();
        @(negedge ref_clk);
        // full-scale corners first; pushing past sixteen must be refused
        for (int i = 0; i < 18; i++) begin
            resultIn.valid = 1'b1;
            resultIn.data = (i == 0) ? 24'h800000 : (i == 1) ? 24'h7FFFFF : 24'($random(seed));
            if (resultReady === 1'b1) q.push_back(resultIn.data);
            @(negedge ref_clk);
        end
        resultIn.valid = 1'b0;
        check(32'(q.size()), 16);
        check(resultReady, 0);
        waitReady();
        check(near(cyc - t0, CAL), 1);
        readWord(25);
        check(lastBit, 1);
        check(resultReady, 1);
        waitReady();
        t0 = cyc;
        readWord(24);
        repeat (10) @(negedge ref_clk);
        check(rdyDout, q[1][0]);
        waitReady();
        waitReady();
        check(cyc - t0, 2 * CONV);
        readWord(25);
        i_atwrs_host_model.pulse();
        check(status.calActive, 1);
        t0 = cyc;
        waitReady();
        check(near(cyc - t0, CAL - 5), 1);
        readWord(25);
        waitReady();
        i_atwrs_host_model.hold(1'b1);
        repeat (2010) @(negedge ref_clk);
        check(status.sleepActive, 1);
        check(rdyDout, 1);
        i_atwrs_host_model.hold(1'b0);
        t0 = cyc;
        waitReady();
        check(near(cyc - t0, CONV), 1);
        readWord(25);
        i_atwrs_host_model.hold(1'b1);
        repeat (2010) @(negedge ref_clk);
        check(status.sleepActive, 1);
        i_atwrs_host_model.hold(1'b0);
        t0 = cyc;
        waitReady();
        check(near(cyc - t0, WCAL), 1);
        readWord(25);
        // roughly 2.5 MHz on the external clock pin, then let it stop
        repeat (40) begin
            repeat (4) @(negedge ref_clk);
            extClk = ~extClk;
        end
        check(status.extClkSel, 1);
        check(status.oscEnable, 0);
        repeat (80) @(negedge ref_clk);
        check(status.extClkSel, 0);
        results();
    end
endmodule // test_adc_two_wire_readout_sequencer

bind atwrs_sequencer atwrs_sequencer_props i_atwrs_sequencer_props (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .sclk(sclk), .rdyDout(rdyDout),
    .extClk(extClk), .resultIn(resultIn), .resultReady(resultReady), .status(status));
